// ### hdl/recorder_cmd.sv
// Contract
// - rearm re-enters armed state with settings from the last arm write
// - end-of-record command sets the flag and stops digitizing at once
// - soft trigger acts like the external trigger in either mode
// - self-test accepted only when armed, else Q low and no test
// - self-test selects the reference input and triggers digitizing
// - self-test: post mode fills memory; pre mode fills then counts post samples
// - buffer data only returned after an enable-unload write set up unloading
// - compat or four-plus channels: bits 1-18 sample, bits 19-23 channel
// - enable-unload answers Q low if channel not digitized since last arm
// - two channels: bits 1-19 sample, bit 20 channel, upper bits zero
// - one channel: bits 1-20 sample, no channel, upper bits zero
// - start address is oldest plus channels times sample plus channel
// - enable-unload prefetches the word into the buffer, returns no data
// - buffer read returns word, steps (Y+1) times channels, prefetches next
// - buffer read before enable-unload answers Q low with zero data
// - advanced unload address wraps modulo the memory size
// - returned sample is two's complement sign-extended to 16 bits
// - double-span ranges always return the low data bit as zero
// - full memory in post mode sets end of record, ignores clocks until arm
`timescale 1ns/1ps
`default_nettype none
module recorder_cmd
    import recorder_pkg::*;
#(
    parameter int AW    = ADDR_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic                sys_clk_i,
    input  wire logic                rst_b_i,
    input  wire cmd_t                cmd_i,
    output var  resp_t               resp_o,
    input  wire logic                ext_trig_i,
    input  wire logic                compat_i,
    input  wire logic [1:0]          range_i,
    input  wire logic [AW:0]         mem_words_i,
    input  wire logic                sample_valid_i,
    input  wire logic [SAMPLE_W-1:0] sample_data_i,
    output var  logic                sample_ready_o,
    output var  logic                end_record_flag_o,
    output var  logic                digitizing_o,
    output var  logic                armed_o,
    output var  logic                self_test_o
);
    typedef struct packed {
        acq_state_t          st;
        logic [WORD_W-1:0]   arm_word;
        logic                end_rec;
        logic                pre;
        logic [2:0]          ch_code;
        logic [AW-1:0]       wptr;
        logic                wrapped;
        logic [AW-1:0]       oldest;
        logic [MAX_CH-1:0]   seen;
        logic [4:0]          chidx;
        logic [25:0]         left;
        logic                fill_first;
        logic                self_test;
        logic                unl_en;
        logic [AW-1:0]       uaddr;
        logic                fetch;
        logic [SAMPLE_W-1:0] rbuf;
        resp_t               resp;
        logic                dig;
        logic                armed;
    } state_t;

    state_t              s_reg;
    state_t              s_next;
    logic [SAMPLE_W-1:0] mem [2**AW];
    logic                f_valid;
    logic [SAMPLE_W-1:0] f_data;
    logic                f_ready;
    logic                wr_en;
    logic [5:0]          nch;
    logic [19:0]         u_sample;
    logic [4:0]          u_chan;
    logic [AW-1:0]       start_addr;
    logic [AW-1:0]       next_addr;
    logic                is_cmd;
    logic                trig;

    // converter samples queue here while a memory fetch holds the port
    sample_fifo #(
        .WIDTH       (SAMPLE_W),
        .DEPTH       (DEPTH)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (sample_valid_i),
        .in_data_i   (sample_data_i),
        .in_ready_o  (sample_ready_o),
        .out_valid_o (f_valid),
        .out_data_o  (f_data),
        .out_ready_i (f_ready)
    );

    unload_addr_gen #(
        .AW       (AW)
    ) u_addr (
        .oldest_i (s_reg.oldest),
        .nch_i    (nch),
        .sample_i (u_sample),
        .chan_i   (u_chan),
        .cur_i    (s_reg.uaddr),
        .stride_i (cmd_i.sub),
        .size_i   (mem_words_i),
        .start_o  (start_addr),
        .next_o   (next_addr)
    );

    assign nch     = chan_count(s_reg.ch_code);
    assign f_ready = !s_reg.fetch;
    assign wr_en   = f_valid && f_ready
                     && (s_reg.st == ST_RUN || s_reg.st == ST_POST);
    assign is_cmd  = cmd_i.valid;

    // unload word split depends on jumper and channel count
    always_comb begin
        u_sample = 20'(cmd_i.wdata[UNL_SMP_W_WIDE-1:0]);
        u_chan   = cmd_i.wdata[UNL_SMP_W_WIDE +: UNL_CH_W];
        if (!compat_i && s_reg.ch_code == CH_CODE_TWO) begin
            u_sample = 20'(cmd_i.wdata[UNL_SMP_W_TWO-1:0]);
            u_chan   = 5'(cmd_i.wdata[UNL_SMP_W_TWO]);
        end else if (!compat_i && s_reg.ch_code == CH_CODE_ONE) begin
            u_sample = cmd_i.wdata[UNL_SMP_W_ONE-1:0];
            u_chan   = 5'h00;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (wr_en) begin
            mem[s_reg.wptr] <= f_data;
        end
    end

    always_comb begin
        logic [SAMPLE_W:0]     widened;
        logic [AW-1:0]         wp_inc;
        logic                  at_end;
        logic [WORD_W-1:0]     aw;
        logic [DATA_W-1:0]     word;
        widened = '0;
        wp_inc  = '0;
        at_end  = 1'b0;
        aw      = '0;
        word    = '0;
        s_next  = s_reg;
        s_next.resp.valid = 1'b0;
        trig    = ext_trig_i
                  || (is_cmd && cmd_i.fn == FN_CTRL && cmd_i.sub == SA_TRIGGER);

        if (s_reg.fetch) begin
            s_next.rbuf  = mem[s_reg.uaddr];
            s_next.fetch = 1'b0;
        end

        // sample storage while digitizing
        if (wr_en) begin
            at_end = (32'(s_reg.wptr) + 32'h1 >= 32'(mem_words_i));
            wp_inc = at_end ? '0 : s_reg.wptr + 1'b1;
            s_next.wptr = wp_inc;
            s_next.seen[s_reg.chidx] = 1'b1;
            s_next.chidx = (6'(s_reg.chidx) + 6'h1 >= nch) ? 5'h00 : s_reg.chidx + 5'h01;
            if (at_end) begin
                s_next.wrapped = 1'b1;
            end
            if (s_reg.st == ST_RUN && !s_reg.pre && at_end) begin
                s_next.st       = ST_DONE;
                s_next.end_rec  = 1'b1;
                s_next.oldest   = '0;
                s_next.self_test = 1'b0;
            end else if (s_reg.st == ST_RUN && s_reg.fill_first && at_end) begin
                s_next.st         = ST_POST;
                s_next.fill_first = 1'b0;
            end else if (s_reg.st == ST_POST) begin
                s_next.left = s_reg.left - 26'h1;
                if (s_reg.left == 26'h1) begin
                    s_next.st        = ST_DONE;
                    s_next.end_rec   = 1'b1;
                    s_next.self_test = 1'b0;
                    s_next.oldest    = (s_reg.wrapped || at_end) ? wp_inc : '0;
                end
            end
        end

        // trigger: start in post mode, start counting in pre mode
        if (trig && s_next.st == ST_WAIT) begin
            s_next.st = ST_RUN;
        end else if (trig && s_next.st == ST_RUN && s_reg.pre && !s_reg.fill_first) begin
            s_next.st = ST_POST;
        end

        if (is_cmd) begin
            s_next.resp.valid = 1'b1;
            s_next.resp.q     = 1'b1;
            s_next.resp.rdata = '0;
            case (cmd_i.fn)
                FN_WRITE: begin
                    if (cmd_i.sub == SA_ARM) begin
                        s_next.arm_word = cmd_i.wdata;
                    end else if (cmd_i.sub == SA_UNLOAD) begin
                        if (!s_reg.seen[u_chan]) begin
                            s_next.resp.q = 1'b0;
                        end else begin
                            s_next.unl_en = 1'b1;
                            s_next.uaddr  = start_addr;
                            s_next.fetch  = 1'b1;
                        end
                    end else begin
                        s_next.resp.q = 1'b0;
                    end
                end
                FN_READ_BUF: begin
                    if (!s_reg.unl_en) begin
                        s_next.resp.q = 1'b0;
                    end else begin
                        widened = {s_reg.rbuf[SAMPLE_W-1], s_reg.rbuf};
                        word    = DATA_W'($signed(widened));
                        if (range_i == RANGE_UNI_WIDE || range_i == RANGE_BI_WIDE) begin
                            word = {word[DATA_W-2:0], 1'b0};
                        end
                        s_next.resp.rdata = word;
                        s_next.uaddr      = next_addr;
                        s_next.fetch      = 1'b1;
                    end
                end
                FN_CTRL: begin
                    if (cmd_i.sub == SA_END_REC) begin
                        s_next.end_rec   = 1'b1;
                        s_next.st        = ST_DONE;
                        s_next.self_test = 1'b0;
                        s_next.oldest    = s_reg.wrapped ? s_reg.wptr : '0;
                    end else if (cmd_i.sub == SA_SELFTEST) begin
                        if (s_reg.st == ST_WAIT || s_reg.st == ST_RUN) begin
                            s_next.self_test = 1'b1;
                            s_next.st        = ST_RUN;
                            s_next.fill_first = s_reg.pre && !s_reg.wrapped;
                            if (s_reg.pre && s_reg.wrapped) begin
                                s_next.st = ST_POST;
                            end
                        end else begin
                            s_next.resp.q = 1'b0;
                        end
                    end
                end
                default: begin
                    s_next.resp.q = (cmd_i.fn == FN_REARM);
                end
            endcase

            // arm write arms from the written word, rearm from the held word
            if ((cmd_i.fn == FN_WRITE && cmd_i.sub == SA_ARM) || cmd_i.fn == FN_REARM) begin
                aw = (cmd_i.fn == FN_REARM) ? s_reg.arm_word : cmd_i.wdata;
                s_next.pre        = aw[ARM_PRE_BIT];
                s_next.ch_code    = aw[ARM_CH_LSB +: ARM_CH_W];
                s_next.left       = 26'(chan_count(aw[ARM_CH_LSB +: ARM_CH_W]))
                                    * 26'({aw[ARM_POST_LSB +: ARM_POST_W], 4'h0});
                s_next.st         = aw[ARM_PRE_BIT] ? ST_RUN : ST_WAIT;
                s_next.end_rec    = 1'b0;
                s_next.wptr       = '0;
                s_next.wrapped    = 1'b0;
                s_next.oldest     = '0;
                s_next.seen       = '0;
                s_next.chidx      = '0;
                s_next.fill_first = 1'b0;
                s_next.self_test  = 1'b0;
            end
        end
        // status decoded ahead so the outputs leave straight from flops
        s_next.dig   = (s_next.st == ST_RUN) || (s_next.st == ST_POST);
        s_next.armed = (s_next.st == ST_WAIT) || (s_next.st == ST_RUN);
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            s_reg          <= '0;
            s_reg.st       <= ST_IDLE;
            s_reg.arm_word <= ARM_WORD_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign resp_o            = s_reg.resp;
    assign end_record_flag_o = s_reg.end_rec;
    assign digitizing_o      = s_reg.dig;
    assign armed_o           = s_reg.armed;
    assign self_test_o       = s_reg.self_test;
endmodule // recorder_cmd
`default_nettype wire

// ### include/recorder_pkg.sv
package recorder_pkg;

    localparam int ADDR_W      = 20;
    localparam int SAMPLE_W    = 12;
    localparam int DATA_W      = 16;
    localparam int WORD_W      = 24;
    localparam int MAX_CH      = 32;
    localparam int FIFO_DEPTH  = 8;

    // dataway function and subaddress codes
    localparam logic [4:0] FN_READ_BUF = 5'h02;
    localparam logic [4:0] FN_WRITE    = 5'h10;
    localparam logic [4:0] FN_CTRL     = 5'h19;
    localparam logic [4:0] FN_REARM    = 5'h1a;
    localparam logic [3:0] SA_ARM      = 4'h0;
    localparam logic [3:0] SA_UNLOAD   = 4'h1;
    localparam logic [3:0] SA_END_REC  = 4'h0;
    localparam logic [3:0] SA_SELFTEST = 4'h1;
    localparam logic [3:0] SA_TRIGGER  = 4'h2;

    // arm word layout (W1 is bit 0)
    localparam int ARM_PRE_BIT  = 0;
    localparam int ARM_CH_LSB   = 4;
    localparam int ARM_CH_W     = 3;
    localparam int ARM_POST_LSB = 8;
    localparam int ARM_POST_W   = 16;
    localparam int BLOCK_SHIFT  = 4;

    // enable-unload word layout
    localparam int UNL_SMP_W_WIDE = 18;
    localparam int UNL_SMP_W_TWO  = 19;
    localparam int UNL_SMP_W_ONE  = 20;
    localparam int UNL_CH_W       = 5;
    localparam logic [2:0] CH_CODE_FOUR = 3'h3;
    localparam logic [2:0] CH_CODE_TWO  = 3'h4;
    localparam logic [2:0] CH_CODE_ONE  = 3'h5;

    // gain codes whose span is twice the base full scale
    localparam logic [1:0] RANGE_UNI_WIDE = 2'h0;
    localparam logic [1:0] RANGE_BI_WIDE  = 2'h3;

    localparam logic [WORD_W-1:0] ARM_WORD_RST = 24'h000000;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_WAIT  = 5'b00010,
        ST_RUN   = 5'b00100,
        ST_POST  = 5'b01000,
        ST_DONE  = 5'b10000
    } acq_state_t;

    typedef struct packed {
        logic              valid;
        logic [4:0]        fn;
        logic [3:0]        sub;
        logic [WORD_W-1:0] wdata;
    } cmd_t;

    typedef struct packed {
        logic              valid;
        logic              q;
        logic [DATA_W-1:0] rdata;
    } resp_t;

    function automatic logic [31:0] wrap_mod(input logic [31:0] v,
                                             input logic [31:0] size);
        wrap_mod = (size == 32'h0) ? 32'h0 : (v % size);
    endfunction

    function automatic logic [5:0] chan_count(input logic [2:0] code);
        chan_count = (code > CH_CODE_ONE) ? 6'h01 : 6'(6'h20 >> code);
    endfunction

endpackage

// ### hdl/sample_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sample_fifo
    import recorder_pkg::*;
#(
    parameter int WIDTH = SAMPLE_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output var  logic             in_ready_o,
    output var  logic             out_valid_o,
    output var  logic [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    rd_reg;
    logic [PW-1:0]    wr_reg;
    logic [PW:0]      cnt_reg;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_reg != (PW+1)'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o  = mem[rd_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_reg] <= in_data_i;
        end
        if (!rst_b_i) begin
            rd_reg  <= '0;
            wr_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // sample_fifo
`default_nettype wire

// ### hdl/unload_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none
module unload_addr_gen
    import recorder_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input  wire logic [AW-1:0] oldest_i,
    input  wire logic [5:0]    nch_i,
    input  wire logic [19:0]   sample_i,
    input  wire logic [4:0]    chan_i,
    input  wire logic [AW-1:0] cur_i,
    input  wire logic [3:0]    stride_i,
    input  wire logic [AW:0]   size_i,
    output var  logic [AW-1:0] start_o,
    output var  logic [AW-1:0] next_o
);
    logic [31:0] start_sum;
    logic [31:0] next_sum;

    // oldest + channels * sample + channel
    assign start_sum = 32'(oldest_i) + 32'(nch_i) * 32'(sample_i) + 32'(chan_i);
    // step (Y+1) * channels from current word
    assign next_sum  = 32'(cur_i) + (32'(stride_i) + 32'h1) * 32'(nch_i);
    // modulo the configured memory size
    assign start_o   = AW'(wrap_mod(start_sum, 32'(size_i)));
    assign next_o    = AW'(wrap_mod(next_sum, 32'(size_i)));
endmodule // unload_addr_gen
`default_nettype wire

// ### test/recorder_cmd_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module recorder_cmd_asserts
    import recorder_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_b_i,
    input  wire cmd_t       cmd_i,
    input  wire resp_t      resp_o,
    input  wire logic       ext_trig_i,
    input  wire logic [1:0] range_i,
    input  wire logic       end_record_flag_o,
    input  wire logic       digitizing_o,
    input  wire logic       armed_o,
    input  wire logic       self_test_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic is_rd;
    logic is_ctl;
    logic was_rd_reg;
    logic was_unl_reg;
    logic seen_reg;
    assign is_rd  = cmd_i.valid && cmd_i.fn == FN_READ_BUF;
    assign is_ctl = cmd_i.valid && cmd_i.fn == FN_CTRL;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            was_rd_reg  <= 1'b0;
            was_unl_reg <= 1'b0;
            seen_reg    <= 1'b0;
        end else begin
            was_rd_reg  <= is_rd;
            was_unl_reg <= cmd_i.valid && cmd_i.fn == FN_WRITE && cmd_i.sub == SA_UNLOAD;
            // a refused unload sets nothing up
            if (was_unl_reg && resp_o.valid && resp_o.q) begin
                seen_reg <= 1'b1;
            end
        end
    end
    property p_answer; cmd_i.valid |=> resp_o.valid; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_read_refused; is_rd && !seen_reg |=> !resp_o.q && resp_o.rdata == 16'h0000; endproperty
    a_read_refused: assert property (p_read_refused) else $error("early read");
    property p_st_refused; is_ctl && cmd_i.sub == SA_SELFTEST && !armed_o |=> !resp_o.q; endproperty
    a_st_refused: assert property (p_st_refused) else $error("self test taken");
    property p_st_go;
        is_ctl && cmd_i.sub == SA_SELFTEST && armed_o |=> resp_o.q ##[0:2] (self_test_o && digitizing_o);
    endproperty
    a_st_go: assert property (p_st_go) else $error("self test idle");
    property p_end_rec;
        is_ctl && cmd_i.sub == SA_END_REC |-> ##[1:2] (end_record_flag_o && !digitizing_o);
    endproperty
    a_end_rec: assert property (p_end_rec) else $error("still running");
    property p_rearm;
        cmd_i.valid && cmd_i.fn == FN_REARM |-> ##[1:2] (armed_o && !end_record_flag_o);
    endproperty
    a_rearm: assert property (p_rearm) else $error("rearm lost");
    property p_soft_trig; is_ctl && cmd_i.sub == SA_TRIGGER && armed_o && !digitizing_o |-> ##[1:2] digitizing_o; endproperty
    a_soft_trig: assert property (p_soft_trig) else $error("soft trigger lost");
    property p_ext_trig; ext_trig_i && armed_o && !digitizing_o |-> ##[1:2] digitizing_o; endproperty
    a_ext_trig: assert property (p_ext_trig) else $error("trigger lost");
    property p_wide_lsb;
        was_rd_reg && ($past(range_i) == RANGE_UNI_WIDE || $past(range_i) == RANGE_BI_WIDE) |-> !resp_o.rdata[0];
    endproperty
    a_wide_lsb: assert property (p_wide_lsb) else $error("odd wide word");
    property p_sign; was_rd_reg |-> resp_o.rdata[15:12] == 4'h0 || resp_o.rdata[15:12] == 4'hf; endproperty
    a_sign: assert property (p_sign) else $error("sign not extended");
    property p_eor_hold; end_record_flag_o && !cmd_i.valid |=> end_record_flag_o && !digitizing_o; endproperty
    a_eor_hold: assert property (p_eor_hold) else $error("record resumed");
endmodule // recorder_cmd_asserts
bind recorder_cmd recorder_cmd_asserts u_asserts (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cmd_i(cmd_i), .resp_o(resp_o),
    .ext_trig_i(ext_trig_i), .range_i(range_i), .end_record_flag_o(end_record_flag_o),
    .digitizing_o(digitizing_o), .armed_o(armed_o), .self_test_o(self_test_o));
`default_nettype wire

// ### test/crate_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module crate_ctrl_model
    import recorder_pkg::*;
(
    input  wire logic  sys_clk_i,
    input  wire resp_t resp_i,
    output var  cmd_t  cmd_o
);
    initial cmd_o = '0;
    task automatic issue(input logic [4:0] fn, input logic [3:0] sub, input logic [WORD_W-1:0] w,
                         output logic q, output logic [DATA_W-1:0] rd, output logic ok);
        int n;
        @(negedge sys_clk_i);
        cmd_o = '{valid: 1'b1, fn: fn, sub: sub, wdata: w};
        @(negedge sys_clk_i);
        // released lines show the inverse, never a stale copy
        cmd_o = '{valid: 1'b0, fn: ~fn, sub: ~sub, wdata: ~w};
        n = 0;
        while (resp_i.valid !== 1'b1 && n < 4) begin
            @(negedge sys_clk_i);
            n++;
        end
        ok = (n < 4);
        q  = resp_i.q;
        rd = resp_i.rdata;
        // prefetch needs an idle cycle before the next read
        @(negedge sys_clk_i);
    endtask
endmodule // crate_ctrl_model
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import recorder_pkg::*;
;
    localparam int AW = 8;
    logic                sys_clk = 1'b0;
    logic                rst_b, ext_trig, compat, smp_valid, smp_ready, end_record_flag, dig, armed, stest;
    logic                q_seen, ok;
    logic [1:0]          range_sel;
    logic [15:0]         rd_seen;
    logic [SAMPLE_W-1:0] smp_data;
    logic [SAMPLE_W-1:0] mem_img [16];
    cmd_t                cmd;
    resp_t               resp;
    int                  error_cnt, compares, cycles, wr_idx, smp_k;
    always #10 sys_clk = ~sys_clk;
    recorder_cmd #(.AW(AW), .DEPTH(FIFO_DEPTH)) dut (
        .sys_clk_i(sys_clk), .rst_b_i(rst_b), .cmd_i(cmd), .resp_o(resp), .ext_trig_i(ext_trig),
        .compat_i(compat), .range_i(range_sel), .mem_words_i(9'h010), .sample_valid_i(smp_valid),
        .sample_data_i(smp_data), .sample_ready_o(smp_ready), .end_record_flag_o(end_record_flag),
        .digitizing_o(dig), .armed_o(armed), .self_test_o(stest));
    crate_ctrl_model ctl (.sys_clk_i(sys_clk), .resp_i(resp), .cmd_o(cmd));
    task automatic tally_and_finish();
        if (error_cnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic chk_word(input string what, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_bit(input string what, input logic e, input logic g);
        chk_word(what, {15'h0000, e}, {15'h0000, g});
    endtask
    function automatic logic [15:0] expv(input logic [11:0] s, input logic [1:0] r);
        expv = {{4{s[11]}}, s};
        if (r == RANGE_UNI_WIDE || r == RANGE_BI_WIDE) expv = {expv[14:0], 1'b0};
    endfunction
    task automatic run(input logic [4:0] f, input logic [3:0] s, input logic [23:0] w, input logic eq);
        ctl.issue(f, s, w, q_seen, rd_seen, ok);
        chk_bit("answer", 1'b1, ok);
        chk_bit("q", eq, q_seen);
    endtask
    task automatic rd(input logic [3:0] y, input int a);
        run(FN_READ_BUF, y, 24'h000000, 1'b1);
        chk_word("read data", expv(mem_img[a], range_sel), rd_seen);
    endtask
    task automatic push(input bit keep);
        int n;
        @(negedge sys_clk);
        smp_k++;
        smp_valid = 1'b1;
        smp_data  = SAMPLE_W'(smp_k * 32'h123 + 32'h801);
        n = 0;
        while (smp_ready !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        if (keep) begin
            mem_img[wr_idx] = smp_data;
            wr_idx = (wr_idx + 1) % 16;
        end
    endtask
    task automatic settle(input int n);
        @(negedge sys_clk);
        smp_valid = 1'b0;
        smp_data  = ~smp_data;
        repeat (n) @(negedge sys_clk);
    endtask
    // arm, refuse an unseen channel, start, then fill exactly to the stop point
    task automatic fill(input logic [4:0] f, input logic [23:0] w, input logic [3:0] s,
                        input int npre, input bit ext);
        int n;
        run(f, SA_ARM, w, 1'b1);
        run(FN_WRITE, SA_UNLOAD, 24'h000000, 1'b0);
        chk_bit("armed", 1'b1, armed);
        wr_idx = 0;
        repeat (npre) push(1'b1);
        settle(6);
        if (ext) begin
            @(negedge sys_clk);
            ext_trig = 1'b1;
            @(negedge sys_clk);
            ext_trig = 1'b0;
        end else begin
            run(FN_CTRL, s, 24'h000000, 1'b1);
            if (s == SA_SELFTEST) chk_bit("self test", 1'b1, stest);
        end
        chk_bit("digitizing", 1'b1, dig);
        repeat (15) push(1'b1);
        settle(6);
        chk_bit("early end", 1'b0, end_record_flag);
        push(1'b1);
        settle(0);
        n = 0;
        while (end_record_flag !== 1'b1 && n < 10) begin
            @(negedge sys_clk);
            n++;
        end
        chk_bit("end flag", 1'b1, end_record_flag);
        chk_bit("stopped", 1'b0, dig);
    endtask
    initial begin
        {rst_b, ext_trig, compat, smp_valid} = '0;
        {smp_data, range_sel} = {12'h000, 2'h1};
        repeat (8) @(negedge sys_clk);
        rst_b = 1'b1;
        chk_bit("ready", 1'b1, smp_ready);
        run(FN_READ_BUF, 4'h0, 24'h000000, 1'b0);
        chk_word("read data", 16'h0000, rd_seen);
        run(FN_CTRL, SA_SELFTEST, 24'h000000, 1'b0);
        fill(FN_WRITE, 24'h000050, SA_TRIGGER, 0, 1'b0);
        push(1'b0);
        settle(4);
        chk_bit("end flag", 1'b1, end_record_flag);
        run(FN_WRITE, SA_UNLOAD, 24'h00000e, 1'b1);
        rd(4'h0, 14);
        rd(4'h1, 15);
        rd(4'h0, 1);
        for (int r = 0; r < 4; r++) begin
            range_sel = 2'(r);
            rd(4'h0, 2 + r);
        end
        range_sel = 2'h1;
        fill(FN_REARM, 24'h000000, SA_SELFTEST, 0, 1'b0);
        run(FN_WRITE, SA_UNLOAD, 24'h000005, 1'b1);
        rd(4'h0, 5);
        fill(FN_WRITE, 24'h000040, SA_TRIGGER, 0, 1'b1);
        run(FN_WRITE, SA_UNLOAD, 24'h080003, 1'b1);
        rd(4'h0, 7);
        rd(4'h0, 9);
        compat = 1'b1;
        fill(FN_WRITE, 24'h000030, SA_TRIGGER, 0, 1'b0);
        run(FN_WRITE, SA_UNLOAD, 24'h0c0002, 1'b1);
        rd(4'h1, 11);
        rd(4'h0, 3);
        rd(4'h0, 7);
        compat = 1'b0;
        fill(FN_WRITE, 24'h000151, SA_ARM, 5, 1'b1);
        run(FN_WRITE, SA_UNLOAD, 24'h000000, 1'b1);
        rd(4'h0, wr_idx);
        run(FN_WRITE, SA_ARM, 24'h000151, 1'b1);
        run(FN_CTRL, SA_END_REC, 24'h000000, 1'b1);
        chk_bit("end flag", 1'b1, end_record_flag);
        chk_bit("stopped", 1'b0, dig);
        chk_bit("armed", 1'b0, armed);
        // queue drains every cycle, so a steady stream is never refused
        for (int i = 0; i < 9; i++) begin
            @(negedge sys_clk);
            chk_bit("sample ready", 1'b1, smp_ready);
            smp_valid = 1'b1;
        end
        settle(2);
        for (int i = 0; i < 2; i++) begin
            chk_bit("still stopped", 1'b0, dig);
            @(negedge sys_clk);
        end
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
